// File: src/insn_exec_cfg.svh
// Summary of operation
// RULE1 - add and subtract accumulator with file, update carry, digit carry, zero
// RULE2 - destination bit 0 writes accumulator, 1 writes the file register
// RULE3 - or, and, xor, invert, copy, clear file, clear acc touch only zero
// RULE4 - inc/dec set zero; skip forms skip on zero result, no flags
// RULE5 - rotates through carry change carry; nibble exchange and store change nothing
// RULE6 - bit clear and bit set modify one bit, no flags, one cycle
// RULE7 - bit tests skip next instruction on clear or set bit, no flags
// RULE8 - a taken skip discards the fetched word and executes a no-operation
// RULE9 - and, or, xor literal combine with accumulator and update zero
// RULE10 - load literal copies low eight bits into accumulator, no flags
// RULE11 - call pushes return address, loads literal, page bits, clears bit 8
// RULE12 - every counter write clears bit 8 except the unconditional branch; the return here restores the stacked bit 8 rather than clearing it
// RULE13 - return pops the stack and places the literal in the accumulator
// RULE14 - watchdog kick and standby update timeout and powerdown flags
// RULE15 - option load from accumulator; direction load when file field is 6
// RULE16 - direction bit 1 floats the pin, 0 enables its driver
// RULE17 - read-modify-write of the port uses the pin levels
// RULE18 - writing the timer register clears the prescaler when assigned to it
// RULE19 - four oscillator periods per cycle; branches and skips take two
// RULE20 - undefined encodings execute as a single-cycle no-operation
`ifndef INSN_EXEC_CFG_SVH
`define INSN_EXEC_CFG_SVH
`define WB_CTRL     8'h00
`define WB_ACC      8'h04
`define WB_STAT     8'h08
`define WB_PC       8'h0C
`define WB_OPT      8'h10
`define WB_DIR      8'h14
`define F_TIMER     5'h01
`define F_PCL       5'h02
`define F_STATUS    5'h03
`define F_PORT      5'h06
`define DIRECTION_LATCH_PORT   3'h6
`define ST_C        0
`define ST_DC       1
`define ST_Z        2
`define ST_PD       3
`define ST_TO       4
`define OPT_PSA     3
`define STATUS_RST  8'h18
`define OPTION_RST  8'hFF
`define DIR_RST     8'hFF
`define CTRL_RST    1'b1
`define LAST_PHASE  2'h3
`define NOP_WORD    12'h000
`endif

// File: src/insn_exec_pkg.sv
package insn_exec_pkg;
  typedef enum {
    op_nop, op_add, op_sub, op_or, op_and, op_xor, op_com, op_mov, op_clear_file, op_clear_acc,
    op_inc, op_dec, op_incsz, op_decsz, op_rlf, op_rrf, op_swap, op_store_acc,
    op_bcf, op_bsf, op_test_skip_clear, op_test_skip_set, op_and_literal, op_or_literal, op_xor_literal, op_load_literal,
    op_call, op_goto, op_return_with_literal, op_kick, op_sleep, op_option, op_direction_latch
  } op_t;
endpackage

// File: src/insn_exec.sv
`timescale 1ns/100ps
`default_nettype none
`include "insn_exec_cfg.svh"
module insn_exec
  import insn_exec_pkg::*;
#(
  parameter int STACK_DEPTH = 2
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // fetch path
  output logic      [10:0] fetch_addr,
  input  wire logic [11:0] instr_in,
  // file register array
  output logic      [4:0]  file_addr,
  input  wire logic [7:0]  file_rdata,
  output logic             file_we,
  output logic      [4:0]  file_waddr,
  output logic      [7:0]  file_wdata,
  // port pins and side effects
  input  wire logic [7:0]  port_pins,
  output logic      [7:0]  port_drive_en,
  output logic             presc_clr,
  output logic             wdt_clr,
  output logic             standby,
  output logic      [7:0]  option_out
);
  logic        rst_s1_q, rst_n_q;
  logic [7:0]  pin_s1_q, pin_s2_q;
  logic [1:0]  phase_q;
  logic        run_q, ack_q;
  logic [31:0] rdat_q;
  logic [11:0] ir_q;
  logic [10:0] pc_q;
  logic [7:0]  acc_q, status_q, option_q, dir_q, drive_q;
  logic [10:0] stk_q [STACK_DEPTH];
  logic        fwe_q, presc_q, wdt_q, stby_q;
  logic [4:0]  fwa_q;
  logic [7:0]  fwd_q;
  op_t         op;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end
  // instruction decode
  always_comb begin
    casez (ir_q)
      12'b0000_0000_0010: op = op_option;
      12'b0000_0000_0011: op = op_sleep;
      12'b0000_0000_0100: op = op_kick;
      12'b0000_0000_0???: op = (ir_q[2:0] == `DIRECTION_LATCH_PORT) ? op_direction_latch : op_nop;
      12'b0000_0100_0000: op = op_clear_acc;
      12'b0000_001?_????: op = op_store_acc;
      12'b0000_011?_????: op = op_clear_file;
      12'b0000_10??_????: op = op_sub;
      12'b0000_11??_????: op = op_dec;
      12'b0001_00??_????: op = op_or;
      12'b0001_01??_????: op = op_and;
      12'b0001_10??_????: op = op_xor;
      12'b0001_11??_????: op = op_add;
      12'b0010_00??_????: op = op_mov;
      12'b0010_01??_????: op = op_com;
      12'b0010_10??_????: op = op_inc;
      12'b0010_11??_????: op = op_decsz;
      12'b0011_00??_????: op = op_rrf;
      12'b0011_01??_????: op = op_rlf;
      12'b0011_10??_????: op = op_swap;
      12'b0011_11??_????: op = op_incsz;
      12'b0100_????_????: op = op_bcf;
      12'b0101_????_????: op = op_bsf;
      12'b0110_????_????: op = op_test_skip_clear;
      12'b0111_????_????: op = op_test_skip_set;
      12'b1000_????_????: op = op_return_with_literal;
      12'b1001_????_????: op = op_call;
      12'b101?_????_????: op = op_goto;
      12'b1100_????_????: op = op_load_literal;
      12'b1101_????_????: op = op_or_literal;
      12'b1110_????_????: op = op_and_literal;
      12'b1111_????_????: op = op_xor_literal;
      // RULE20 undefined as nop
      default:            op = op_nop;
    endcase
  end
  wire [4:0] faddr  = ir_q[4:0];
  wire       dst_f  = ir_q[5];
  wire [7:0] lit    = ir_q[7:0];
  wire [7:0] bmask  = 8'h01 << ir_q[7:5];
  wire       ex     = run_q && (phase_q == `LAST_PHASE);
  // RULE17 port operand from pins
  wire [7:0] opnd   = (faddr == `F_PORT)   ? pin_s2_q :
                      (faddr == `F_STATUS) ? status_q :
                      (faddr == `F_PCL)    ? pc_q[7:0] : file_rdata;
  wire [8:0] sum9   = {1'b0, opnd} + {1'b0, acc_q};
  wire [4:0] sumlo  = {1'b0, opnd[3:0]} + {1'b0, acc_q[3:0]};
  wire [7:0] diff   = opnd - acc_q;
  wire       bit_v  = |(opnd & bmask);
  logic [7:0]  res, status_d;
  logic        wr_f, wr_a, upd_z, upd_c, upd_dc, c_n, dc_n, skip, pc_ld, push, pop;
  logic [10:0] pc_new;
  always_comb begin
    res    = opnd;
    wr_f   = 1'b0;
    wr_a   = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    c_n    = status_q[`ST_C];
    dc_n   = status_q[`ST_DC];
    skip   = 1'b0;
    pc_ld  = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    pc_new = pc_q;
    case (op)
      // RULE1 add and subtract
      op_add: begin
        res = sum9[7:0];
        c_n = sum9[8];
        dc_n = sumlo[4];
        {upd_z, upd_c, upd_dc} = 3'h7;
      end
      op_sub: begin
        res = diff;
        c_n = (opnd >= acc_q);
        dc_n = (opnd[3:0] >= acc_q[3:0]);
        {upd_z, upd_c, upd_dc} = 3'h7;
      end
      // RULE3 zero-only logic ops
      op_or:   begin res = opnd | acc_q; upd_z = 1'b1; end
      op_and:  begin res = opnd & acc_q; upd_z = 1'b1; end
      op_xor:  begin res = opnd ^ acc_q; upd_z = 1'b1; end
      op_com:  begin res = ~opnd;        upd_z = 1'b1; end
      op_mov:  begin res = opnd;         upd_z = 1'b1; end
      op_clear_file: begin res = 8'h00; upd_z = 1'b1; end
      op_clear_acc: begin res = 8'h00; upd_z = 1'b1; end
      // RULE4 increment and decrement
      op_inc:   begin res = opnd + 8'h01; upd_z = 1'b1; end
      op_dec:   begin res = opnd - 8'h01; upd_z = 1'b1; end
      op_incsz: begin res = opnd + 8'h01; skip = (res == 8'h00); end
      op_decsz: begin res = opnd - 8'h01; skip = (res == 8'h00); end
      // RULE5 rotates and exchange
      op_rlf:  begin {c_n, res} = {opnd, status_q[`ST_C]}; upd_c = 1'b1; end
      op_rrf:  begin {res, c_n} = {status_q[`ST_C], opnd}; upd_c = 1'b1; end
      op_swap: res = {opnd[3:0], opnd[7:4]};
      op_store_acc: res = acc_q;
      // RULE6 single bit modify
      op_bcf: res = opnd & ~bmask;
      op_bsf: res = opnd | bmask;
      // RULE7 bit tests
      op_test_skip_clear: skip = ~bit_v;
      op_test_skip_set: skip = bit_v;
      // RULE9 literal logic
      op_and_literal: begin res = acc_q & lit; upd_z = 1'b1; end
      op_or_literal: begin res = acc_q | lit; upd_z = 1'b1; end
      op_xor_literal: begin res = acc_q ^ lit; upd_z = 1'b1; end
      // RULE10 load literal
      op_load_literal: res = lit;
      // RULE11 call
      op_call: begin
        push = 1'b1;
        pc_ld = 1'b1;
        pc_new = {status_q[6:5], 1'b0, lit};
      end
      // RULE12 branch keeps bit 8 from literal
      op_goto: begin
        pc_ld = 1'b1;
        pc_new = {status_q[6:5], ir_q[8:0]};
      end
      // RULE13 return with literal
      op_return_with_literal: begin
        pop = 1'b1;
        pc_ld = 1'b1;
        pc_new = stk_q[0];
        res = lit;
      end
      default: res = opnd;
    endcase
    // RULE2 destination select
    case (op)
      op_add, op_sub, op_or, op_and, op_xor, op_com, op_mov, op_inc, op_dec,
      op_incsz, op_decsz, op_rlf, op_rrf, op_swap: begin
        wr_f = dst_f;
        wr_a = ~dst_f;
      end
      op_clear_file, op_store_acc, op_bcf, op_bsf: wr_f = 1'b1;
      op_clear_acc, op_and_literal, op_or_literal, op_xor_literal, op_load_literal, op_return_with_literal: wr_a = 1'b1;
      default: wr_f = 1'b0;
    endcase
    // RULE12 counter low byte write clears bit 8
    if (wr_f && faddr == `F_PCL) begin
      pc_ld = 1'b1;
      pc_new = {status_q[6:5], 1'b0, res};
    end
  end
  always_comb begin
    status_d = status_q;
    if (wr_f && faddr == `F_STATUS) begin
      status_d = {res[7:5], status_q[`ST_TO], status_q[`ST_PD], res[2:0]};
    end
    if (upd_z) status_d[`ST_Z] = (res == 8'h00);
    if (upd_c) status_d[`ST_C] = c_n;
    if (upd_dc) status_d[`ST_DC] = dc_n;
    // RULE14 kick and standby flags
    if (op == op_kick) begin
      status_d[`ST_TO] = 1'b1;
      status_d[`ST_PD] = 1'b1;
    end else if (op == op_sleep) begin
      status_d[`ST_TO] = 1'b1;
      status_d[`ST_PD] = 1'b0;
    end
  end
  wire ext_wr  = wr_f && (faddr != `F_STATUS) && (faddr != `F_PCL);
  // RULE18 timer write clears prescaler
  wire tmr_clr = ext_wr && (faddr == `F_TIMER) && !option_q[`OPT_PSA];
  // RULE19 four periods per cycle
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= 2'h0;
    end else if (run_q) begin
      phase_q <= phase_q + 2'h1;
    end
  end
  // RULE8 flush fetched word on skip or jump
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ir_q <= `NOP_WORD;
      pc_q <= 11'h000;
    end else if (ex) begin
      ir_q <= (skip || pc_ld) ? `NOP_WORD : instr_in;
      pc_q <= pc_ld ? pc_new : pc_q + 11'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (ex && push) begin
      stk_q[0] <= pc_q;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stk_q[i] <= stk_q[i-1];
      end
    end else if (ex && pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stk_q[i] <= stk_q[i+1];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q    <= 8'h00;
      status_q <= `STATUS_RST;
      option_q <= `OPTION_RST;
      dir_q    <= `DIR_RST;
      drive_q  <= ~`DIR_RST;
    end else if (ex) begin
      status_q <= status_d;
      if (wr_a) begin
        acc_q <= res;
      end
      // RULE15 option and direction loads
      if (op == op_option) begin
        option_q <= acc_q;
      end
      if (op == op_direction_latch) begin
        dir_q <= acc_q;
        // RULE16 one floats, zero drives
        drive_q <= ~acc_q;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fwe_q   <= 1'b0;
      fwa_q   <= 5'h00;
      fwd_q   <= 8'h00;
      presc_q <= 1'b0;
      wdt_q   <= 1'b0;
      stby_q  <= 1'b0;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      fwe_q   <= ex && ext_wr;
      fwa_q   <= faddr;
      fwd_q   <= res;
      presc_q <= ex && tmr_clr;
      wdt_q   <= ex && (op == op_kick);
      stby_q  <= ex && (op == op_sleep);
      pin_s1_q <= port_pins;
      pin_s2_q <= pin_s1_q;
    end
  end
  // wishbone slave
  wire        wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire        wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  wire [31:0] rd_mux = (wb_adr_i == `WB_CTRL) ? {31'h0, run_q} :
                       (wb_adr_i == `WB_ACC)  ? {24'h0, acc_q} :
                       (wb_adr_i == `WB_STAT) ? {24'h0, status_q} :
                       (wb_adr_i == `WB_PC)   ? {21'h0, pc_q} :
                       (wb_adr_i == `WB_OPT)  ? {24'h0, option_q} :
                       (wb_adr_i == `WB_DIR)  ? {24'h0, dir_q} : 32'h0;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
      run_q  <= `CTRL_RST;
    end else begin
      ack_q  <= wb_req;
      rdat_q <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
      if (wb_wr && wb_sel_i[0] && wb_adr_i == `WB_CTRL) begin
        run_q <= wb_dat_i[0];
      end
    end
  end
  assign wb_dat_o      = rdat_q;
  assign wb_ack_o      = ack_q;
  assign fetch_addr    = pc_q;
  assign file_addr     = ir_q[4:0];
  assign file_we       = fwe_q;
  assign file_waddr    = fwa_q;
  assign file_wdata    = fwd_q;
  assign port_drive_en = drive_q;
  assign presc_clr     = presc_q;
  assign wdt_clr       = wdt_q;
  assign standby       = stby_q;
  assign option_out    = option_q;
endmodule
`default_nettype wire

// File: tb/insn_exec_props.sv
`timescale 1ns/100ps
`default_nettype none
module insn_exec_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // execution
  input wire logic [10:0] fetch_addr,
  input wire logic        file_we,
  input wire logic [4:0]  file_waddr,
  input wire logic [7:0]  option_out,
  input wire logic        presc_clr,
  input wire logic        wdt_clr,
  input wire logic        standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  AST_FETCH_GAP: assert property ($changed(fetch_addr) |=> $stable(fetch_addr) [*3])
    else $error("counter moved inside an instruction cycle");
  AST_WE_GAP: assert property (file_we |=> !file_we [*3])
    else $error("file write pulse too long");
  AST_WE_PC: assert property (file_we |-> $changed(fetch_addr))
    else $error("file write away from execute edge");
  AST_PRESC: assert property (presc_clr == (file_we && file_waddr == 5'h01 && !option_out[3]))
    else $error("prescaler clear mismatch");
  AST_PULSE_GAP: assert property (wdt_clr || standby |=> !(wdt_clr || standby) [*3])
    else $error("watchdog or standby pulse too long");
  AST_KICK_STBY: assert property (!(wdt_clr && standby))
    else $error("watchdog and standby together");
endmodule
bind insn_exec insn_exec_props u_props (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .fetch_addr(fetch_addr),
  .file_we(file_we), .file_waddr(file_waddr), .option_out(option_out),
  .presc_clr(presc_clr), .wdt_clr(wdt_clr), .standby(standby));
`default_nettype wire

// File: tb/prog_file_model.sv
`timescale 1ns/100ps
`default_nettype none
module prog_file_model (
  input wire logic        clk,
  // fetch path
  input wire logic [10:0] fetch_addr,
  output logic     [11:0] instr_in,
  // file array
  input wire logic [4:0]  file_addr,
  output logic     [7:0]  file_rdata,
  input wire logic        file_we,
  input wire logic [4:0]  file_waddr,
  input wire logic [7:0]  file_wdata
);
  logic [11:0] rom [0:2047];
  logic [7:0]  ram [0:31];
  // unused program words read as no-operation
  initial begin
    for (int i = 0; i < 2048; i++) rom[i] = 12'h000;
    for (int i = 0; i < 32; i++) ram[i] = 8'h00;
  end
  assign instr_in   = rom[fetch_addr];
  assign file_rdata = ram[file_addr];
  always @(posedge clk) begin
    if (file_we) ram[file_waddr] <= file_wdata;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import insn_exec_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, file_we, presc_clr, wdt_clr, standby;
  logic [10:0] fetch_addr;
  logic [11:0] instr_in;
  logic [4:0]  file_addr, file_waddr;
  logic [7:0]  file_rdata, file_wdata, port_drive_en, option_out;
  logic [7:0]  pins = 8'h5A;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0;
  int          n_presc = 0, n_wdt = 0, n_stby = 0;
  localparam logic [11:0] PROG [18] = '{12'hC00, 12'h002, 12'h021, 12'hC0F, 12'h030,
    12'h1F0, 12'h090, 12'h730, 12'h033, 12'h3F1, 12'h033, 12'h5F2, 12'h001, 12'h004,
    12'h920, 12'h006, 12'h003, 12'hA11};
  always #50 clk = ~clk;
  insn_exec dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fetch_addr(fetch_addr), .instr_in(instr_in),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .port_pins(pins),
    .port_drive_en(port_drive_en), .presc_clr(presc_clr), .wdt_clr(wdt_clr),
    .standby(standby), .option_out(option_out));
  prog_file_model m (.clk(clk), .fetch_addr(fetch_addr), .instr_in(instr_in),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata));
  task automatic report_and_stop;
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (presc_clr === 1'b1) n_presc++;
    if (wdt_clr === 1'b1) n_wdt++;
    if (standby === 1'b1) n_stby++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // program: arithmetic, skips, bit set, call and return, side effects
  task automatic test_program;
    while (n_stby == 0) @(posedge clk);
    repeat (8) @(posedge clk);
    check(m.ram[5'h10], 32'h1E);
    check(m.ram[5'h11], 32'h00);
    check(m.ram[5'h12], 32'h80);
    check(m.ram[5'h13], 32'h00);
    check(m.ram[5'h06], 32'hA5);
    check(n_presc, 32'd1);
    check(n_wdt, 32'd1);
    check(port_drive_en, 32'hC3);
    check(option_out, 32'h00);
  endtask
  task automatic test_regs;
    wb_xfer(1'b0, 8'h04, 32'h0);
    check(q, 32'h3C);
    wb_xfer(1'b0, 8'h08, 32'h0);
    check(q, 32'h11);
    wb_xfer(1'b0, 8'h14, 32'h0);
    check(q, 32'h3C);
    wb_xfer(1'b0, 8'h3C, 32'h0);
    check(q, 32'h0);
  endtask
  // stopping execution freezes the counter
  task automatic test_run_ctrl;
    logic [31:0] pc0;
    wb_xfer(1'b1, 8'h00, 32'h0);
    wb_xfer(1'b0, 8'h00, 32'h0);
    check(q, 32'h0);
    wb_xfer(1'b0, 8'h0C, 32'h0);
    pc0 = q;
    repeat (9) @(posedge clk);
    wb_xfer(1'b0, 8'h0C, 32'h0);
    check(q, pc0);
    check(fetch_addr, pc0[10:0]);
  endtask
  initial begin
    #1;
    for (int i = 0; i < 18; i++) m.rom[i] = PROG[i];
    m.rom[11'h020] = 12'h266;
    m.rom[11'h021] = 12'h83C;
    m.ram[5'h11] = 8'hFF;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    test_program();
    test_regs();
    test_run_ctrl();
    report_and_stop();
  end
endmodule
`default_nettype wire
